/* smpu_cfg.sv */
// Configuration, sync routing, clock prescaler and pin shaping of the PWM unit.
//
// Operation
// - Phase offset set: sync out from phase event, latch set by synced period event.
// - Phase offset clear: sync out from period event, latch set by phase event.
// - Period event invert bit inverts selected asynchronous period event inputs.
// - Duty event invert bit inverts selected asynchronous duty-cycle event inputs.
// - Sync select: 000 own period event, 001..100 sync out of unit one..four.
// - Prescaler field divides module clock by one, two, four or eight.
// - Clock source: 00 system clock, 01 PLL, 10 external pin, 11 reserved.
// - Output enable bit routes PWM onto pin, else pin goes back to port.
// - Unit two has only outputs A and B; other bits read zero.
// - Output polarity bit makes that PWM output active low.
// - Input polarity bit treats the external event input as active low.
// - Falling blank mode: 00 none, 01 immediate; 10 and 11 reserved.
// - Rising blank mode: 00 none, 01 immediate; 10 and 11 reserved.
// - Unimplemented bits read zero and ignore writes.
// - All implemented bits reset to zero on every reset.
// - While blanking, selected event sources cannot cause rising or falling events.
`timescale 1ns/1ps
`include "smpu_map.svh"

module smpu_cfg
    import smpu_pkg::*;
#(
    parameter int UNIT_NUM = 3
) (
    // Clock and reset.
    input  wire logic       i_sys_clk,
    input  wire logic       i_arst_n,
    // Register port.
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // Clock sources, sampled as enables on the system clock.
    input  wire logic       i_pll_clk_tick,
    input  wire logic       i_external_clock_pin,
    // Events from the time base and sync network.
    input  wire logic       i_period_evt,
    input  wire logic       i_phase_evt,
    input  wire logic [3:0] i_sync_out_units,
    input  wire logic       i_async_period_evt,
    input  wire logic       i_async_duty_evt,
    input  wire logic       i_external_event_input,
    input  wire logic       i_rise_blank_active,
    input  wire logic       i_fall_blank_active,
    input  wire logic [5:0] i_pwm_raw,
    // Results.
    output logic            o_sync_out,
    output logic            o_sync_in,
    output logic            o_latch_set,
    output logic            o_period_evt,
    output logic            o_duty_evt,
    output logic            o_ext_evt,
    output logic            o_rise_evt_allowed,
    output logic            o_fall_evt_allowed,
    output logic            o_tb_tick,
    output logic            o_tb_idle,
    output logic      [5:0] o_output_pin_enable,
    output logic      [5:0] o_pwm_pin
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0] sync_control_unit3_q;
    logic [7:0] sync_control_unit4_q;
    logic [7:0] clock_select_q;
    logic [7:0] output_enable_q;
    logic [7:0] output_polarity_q;
    logic [7:0] blanking_mode_q;
    logic [7:0] oen_mask;
    logic [7:0] pol_mask;

    // Unit two physically lacks outputs C to F, so those bits are masked away.
    assign oen_mask = (UNIT_NUM == 2) ? `SMPU_OEN_MASK_U2 : `SMPU_OEN_MASK;
    assign pol_mask = (UNIT_NUM == 2) ? `SMPU_POL_MASK_U2 : `SMPU_POL_MASK;

    // Writes store only implemented bits; reset clears all of them.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync_control_unit3_q <= `SMPU_RST_VAL;
            sync_control_unit4_q <= `SMPU_RST_VAL;
            clock_select_q       <= `SMPU_RST_VAL;
            output_enable_q      <= `SMPU_RST_VAL;
            output_polarity_q    <= `SMPU_RST_VAL;
            blanking_mode_q      <= `SMPU_RST_VAL;
        end else if (i_wr) begin
            case (i_addr)
                `SMPU_OFS_SYNC_U3:    sync_control_unit3_q <= i_wdata & `SMPU_SYNC_MASK;
                `SMPU_OFS_SYNC_U4:    sync_control_unit4_q <= i_wdata & `SMPU_SYNC_MASK;
                `SMPU_OFS_CLK_SEL:    clock_select_q       <= i_wdata & `SMPU_CLK_MASK;
                `SMPU_OFS_OUT_EN:     output_enable_q      <= i_wdata & oen_mask;
                `SMPU_OFS_OUT_POL:    output_polarity_q    <= i_wdata & pol_mask;
                `SMPU_OFS_BLANK_MODE: blanking_mode_q      <= i_wdata & `SMPU_BLNK_MASK;
                default: begin
                end
            endcase
        end
    end

    // Read data stands one cycle after the strobe; unmapped offsets read zero.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `SMPU_OFS_SYNC_U3:    o_rdata <= sync_control_unit3_q;
                `SMPU_OFS_SYNC_U4:    o_rdata <= sync_control_unit4_q;
                `SMPU_OFS_CLK_SEL:    o_rdata <= clock_select_q;
                `SMPU_OFS_OUT_EN:     o_rdata <= output_enable_q;
                `SMPU_OFS_OUT_POL:    o_rdata <= output_polarity_q;
                `SMPU_OFS_BLANK_MODE: o_rdata <= blanking_mode_q;
                default:              o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisation routing.

    logic [7:0] sync_reg;
    logic       phase_offset;
    logic [2:0] sync_sel;
    logic       sync_in_d;

    // Units three and four have their own sync register; others use unit three's layout.
    assign sync_reg     = (UNIT_NUM == 4) ? sync_control_unit4_q : sync_control_unit3_q;
    assign phase_offset = sync_reg[`SMPU_BIT_POFST];
    assign sync_sel     = sync_reg[2:0];

    // Reserved codes are not to be written; they fall back to the own period event.
    always_comb begin
        case (sync_sel)
            SMPU_SYNC_OWN: sync_in_d = i_period_evt;
            SMPU_SYNC_U1:  sync_in_d = i_sync_out_units[0];
            SMPU_SYNC_U2:  sync_in_d = i_sync_out_units[1];
            SMPU_SYNC_U3:  sync_in_d = i_sync_out_units[2];
            SMPU_SYNC_U4:  sync_in_d = i_sync_out_units[3];
            default:       sync_in_d = i_period_evt;
        endcase
    end

    // Sync out and latch set swap sources with the phase offset bit.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_sync_out  <= 1'b0;
            o_sync_in   <= 1'b0;
            o_latch_set <= 1'b0;
        end else begin
            o_sync_in   <= sync_in_d;
            o_sync_out  <= phase_offset ? i_phase_evt : i_period_evt;
            o_latch_set <= phase_offset ? sync_in_d : i_phase_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event polarity and blanking.

    logic ext_evt_d;
    logic rise_blank_on;
    logic fall_blank_on;

    assign ext_evt_d     = i_external_event_input ^ output_polarity_q[`SMPU_BIT_POLIN];
    assign rise_blank_on = (blanking_mode_q[1:0] == `SMPU_BLANK_IMMED) && i_rise_blank_active;
    assign fall_blank_on = (blanking_mode_q[5:4] == `SMPU_BLANK_IMMED) && i_fall_blank_active;

    // Inversion is a plain XOR so the polarity bit takes effect on the next edge.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_period_evt       <= 1'b0;
            o_duty_evt         <= 1'b0;
            o_ext_evt          <= 1'b0;
            o_rise_evt_allowed <= 1'b1;
            o_fall_evt_allowed <= 1'b1;
        end else begin
            o_period_evt       <= i_async_period_evt ^ sync_reg[`SMPU_BIT_PRPOL];
            o_duty_evt         <= i_async_duty_evt ^ sync_reg[`SMPU_BIT_DCPOL];
            o_ext_evt          <= ext_evt_d;
            o_rise_evt_allowed <= !rise_blank_on;
            o_fall_evt_allowed <= !fall_blank_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock source and prescaler.

    logic [1:0] clk_src;
    logic [1:0] clk_pre;
    logic       src_tick;
    logic       pin_q;
    logic [2:0] pre_cnt_q;
    logic [2:0] pre_last;
    logic       src_valid;

    assign clk_src   = clock_select_q[1:0];
    assign clk_pre   = clock_select_q[5:4];
    assign src_valid = (clk_src != 2'h3);
    assign pre_last  = 3'((4'h1 << clk_pre) - 4'h1);

    // The pin is compared with its last sample; a rising edge on it is one source tick.
    always_comb begin
        case (clk_src)
            `SMPU_SRC_FOSC: src_tick = 1'b1;
            `SMPU_SRC_PLL:  src_tick = i_pll_clk_tick;
            `SMPU_SRC_PIN:  src_tick = i_external_clock_pin && !pin_q;
            default:        src_tick = 1'b0;
        endcase
    end

    // Prescale counter; held at zero on the reserved source so no tick escapes.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_q     <= 1'b0;
            pre_cnt_q <= 3'h0;
            o_tb_tick <= 1'b0;
            o_tb_idle <= 1'b0;
        end else begin
            pin_q     <= i_external_clock_pin;
            o_tb_idle <= !src_valid;
            o_tb_tick <= 1'b0;
            if (!src_valid) begin
                pre_cnt_q <= 3'h0;
            end else if (src_tick) begin
                if (pre_cnt_q >= pre_last) begin
                    pre_cnt_q <= 3'h0;
                    o_tb_tick <= 1'b1;
                end else begin
                    pre_cnt_q <= pre_cnt_q + 3'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pins.

    // Disabled pins hand over to the port; polarity applies only when enabled.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_output_pin_enable <= 6'h00;
            o_pwm_pin           <= 6'h00;
        end else begin
            o_output_pin_enable <= output_enable_q[5:0];
            o_pwm_pin           <= (i_pwm_raw ^ output_polarity_q[5:0]) & output_enable_q[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    AST_SYNC_OUT_SRC: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $past(phase_offset) |-> o_sync_out == $past(i_phase_evt))
        else $error("sync out not from phase event");
    AST_LATCH_SRC: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !$past(phase_offset) |-> o_latch_set == $past(i_phase_evt))
        else $error("latch set not from phase event");
    AST_PERIOD_INV: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        o_period_evt == ($past(i_async_period_evt) ^ $past(sync_reg[`SMPU_BIT_PRPOL])))
        else $error("period event polarity wrong");
    AST_DUTY_INV: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        o_duty_evt == ($past(i_async_duty_evt) ^ $past(sync_reg[`SMPU_BIT_DCPOL])))
        else $error("duty event polarity wrong");
    AST_SYNC_U4: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (sync_sel == 3'h4) |=> o_sync_in == $past(i_sync_out_units[3]))
        else $error("sync in not from unit four");
    // A new clock setting keeps the old prescale count, so only a held divide-by-eight setting is watched.
    AST_DIV8: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n || clock_select_q[5:0] != 6'h30)
        (o_tb_tick && clk_src == `SMPU_SRC_FOSC && clk_pre == 2'h3 && $stable(clock_select_q))
        |=> !o_tb_tick [*7])
        else $error("divide by eight ticked early");
    AST_RESERVED_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !src_valid |=> !o_tb_tick && o_tb_idle)
        else $error("time base ran on reserved source");
    AST_PIN_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !output_enable_q[0] |=> !o_pwm_pin[0] && !o_output_pin_enable[0])
        else $error("disabled pin still driven");
    AST_U2_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (UNIT_NUM == 2) |-> output_enable_q[5:2] == 4'h0)
        else $error("unit two has outputs above B");
    AST_RES_BITS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        clock_select_q[7:6] == 2'h0 && clock_select_q[3:2] == 2'h0 && sync_control_unit3_q[4:3] == 2'h0)
        else $error("unimplemented bit stored");
    AST_BLANK: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (blanking_mode_q[1:0] == 2'h1 && i_rise_blank_active) |=> !o_rise_evt_allowed)
        else $error("rising blank not applied");
    // Each check below looks one edge after its cause, matching the registered outputs.
    AST_FALL_BLANK: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (blanking_mode_q[5:4] == `SMPU_BLANK_IMMED && i_fall_blank_active) |=> !o_fall_evt_allowed)
        else $error("falling blank not applied");
    AST_NO_RISE_BLANK: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (blanking_mode_q[1:0] == `SMPU_BLANK_NONE) |=> o_rise_evt_allowed)
        else $error("rising event blanked with blanking off");
    AST_NO_FALL_BLANK: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (blanking_mode_q[5:4] == `SMPU_BLANK_NONE) |=> o_fall_evt_allowed)
        else $error("falling event blanked with blanking off");
    AST_BLANK_OPEN: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (!i_rise_blank_active && !i_fall_blank_active) |=> o_rise_evt_allowed && o_fall_evt_allowed)
        else $error("event blocked outside blanking window");
    AST_LATCH_SYNCED: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $past(phase_offset) |-> o_latch_set == $past(sync_in_d))
        else $error("latch set not from synchronous period event");
    AST_SYNC_OUT_PRD: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !$past(phase_offset) |-> o_sync_out == $past(i_period_evt))
        else $error("sync out not from period event");
    AST_SYNC_OWN: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (sync_sel == 3'h0) |=> o_sync_in == $past(i_period_evt))
        else $error("sync in not from own period event");
    AST_SYNC_U1: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (sync_sel == 3'h1) |=> o_sync_in == $past(i_sync_out_units[0]))
        else $error("sync in not from unit one");
    AST_SYNC_U2: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (sync_sel == 3'h2) |=> o_sync_in == $past(i_sync_out_units[1]))
        else $error("sync in not from unit two");
    AST_SYNC_U3: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (sync_sel == 3'h3) |=> o_sync_in == $past(i_sync_out_units[2]))
        else $error("sync in not from unit three");
    AST_EXT_LOW: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        output_polarity_q[`SMPU_BIT_POLIN] |=> o_ext_evt == !$past(i_external_event_input))
        else $error("event input not active low");
    AST_EXT_HIGH: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !output_polarity_q[`SMPU_BIT_POLIN] |=> o_ext_evt == $past(i_external_event_input))
        else $error("event input not active high");
    AST_PIN_DRIVE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        output_enable_q[0] |=> o_pwm_pin[0] == ($past(i_pwm_raw[0]) ^ $past(output_polarity_q[0])))
        else $error("enabled pin polarity wrong");
    AST_DIV1: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (clk_src == `SMPU_SRC_FOSC && clk_pre == 2'h0) |=> o_tb_tick)
        else $error("divide by one missed a tick");
    AST_PLL_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (clk_src == `SMPU_SRC_PLL && !i_pll_clk_tick) |=> !o_tb_tick)
        else $error("tick without a PLL source tick");
    AST_PIN_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (clk_src == `SMPU_SRC_PIN && !i_external_clock_pin) |=> !o_tb_tick)
        else $error("tick without a clock pin edge");

endmodule

/* smpu_map.svh */
// Register offsets, field positions and reset values of the PWM configuration slice.
`ifndef SMPU_MAP_SVH
`define SMPU_MAP_SVH
`define SMPU_OFS_SYNC_U3      4'h0
`define SMPU_OFS_SYNC_U4      4'h1
`define SMPU_OFS_CLK_SEL      4'h2
`define SMPU_OFS_OUT_EN       4'h3
`define SMPU_OFS_OUT_POL      4'h4
`define SMPU_OFS_BLANK_MODE   4'h5
`define SMPU_SYNC_MASK        8'hE7
`define SMPU_CLK_MASK         8'h33
`define SMPU_OEN_MASK         8'h3F
`define SMPU_POL_MASK         8'h7F
`define SMPU_BLNK_MASK        8'h33
`define SMPU_OEN_MASK_U2      8'h03
`define SMPU_POL_MASK_U2      8'h43
`define SMPU_BIT_POFST        7
`define SMPU_BIT_PRPOL        6
`define SMPU_BIT_DCPOL        5
`define SMPU_BIT_POLIN        6
`define SMPU_RST_VAL          8'h00
`define SMPU_BLANK_NONE       2'h0
`define SMPU_BLANK_IMMED      2'h1
`define SMPU_SRC_FOSC         2'h0
`define SMPU_SRC_PLL          2'h1
`define SMPU_SRC_PIN          2'h2
`endif

/* smpu_pkg.sv */
// Types shared by the PWM configuration slice.
package smpu_pkg;
    typedef enum logic [2:0] {
        SMPU_SYNC_OWN,
        SMPU_SYNC_U1,
        SMPU_SYNC_U2,
        SMPU_SYNC_U3,
        SMPU_SYNC_U4
    } smpu_sync_sel_t;
endpackage

/* smpu_power_stage.sv */
// Behavioural model of the power switching stage behind the PWM pins.
`timescale 1ns/1ps

module smpu_power_stage (
    // Pin drive from the PWM unit.
    input  wire logic [5:0] i_pwm_pin,
    input  wire logic [5:0] i_output_pin_enable,
    // Level the general-purpose port puts on a pin it owns.
    input  wire logic [5:0] i_port_level,
    // Level seen at each switch gate.
    output logic      [5:0] o_gate
);
    // A pin whose enable is low belongs to the port again, so the gate follows the port latch.
    assign o_gate = (i_pwm_pin & i_output_pin_enable) | (i_port_level & ~i_output_pin_enable);
endmodule

/* tb.sv */
// Self-checking testbench of the PWM configuration slice.
`timescale 1ns/1ps
`include "smpu_map.svh"

module tb;
    logic       i_sys_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0, i_sync_out_units = 4'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata, rdata_u2;
    logic       i_pll_clk_tick = 1'b0, i_external_clock_pin = 1'b0, i_period_evt = 1'b0, i_phase_evt = 1'b0;
    logic       i_async_period_evt = 1'b0, i_async_duty_evt = 1'b0, i_external_event_input = 1'b0;
    logic       i_rise_blank_active = 1'b0, i_fall_blank_active = 1'b0;
    logic [5:0] i_pwm_raw = 6'h00, o_output_pin_enable, o_pwm_pin, gate;
    logic       o_sync_out, o_sync_in, o_latch_set, o_period_evt, o_duty_evt, o_ext_evt;
    logic       o_rise_evt_allowed, o_fall_evt_allowed, o_tb_tick, o_tb_idle;
    logic [1:0] cyc = 2'h0;
    int         miscompares = 0, n_compared = 0;

    smpu_cfg #(.UNIT_NUM(3)) uut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pll_clk_tick(i_pll_clk_tick),
        .i_external_clock_pin(i_external_clock_pin), .i_period_evt(i_period_evt), .i_phase_evt(i_phase_evt),
        .i_sync_out_units(i_sync_out_units), .i_async_period_evt(i_async_period_evt),
        .i_async_duty_evt(i_async_duty_evt), .i_external_event_input(i_external_event_input),
        .i_rise_blank_active(i_rise_blank_active), .i_fall_blank_active(i_fall_blank_active),
        .i_pwm_raw(i_pwm_raw), .o_sync_out(o_sync_out), .o_sync_in(o_sync_in), .o_latch_set(o_latch_set),
        .o_period_evt(o_period_evt), .o_duty_evt(o_duty_evt), .o_ext_evt(o_ext_evt),
        .o_rise_evt_allowed(o_rise_evt_allowed), .o_fall_evt_allowed(o_fall_evt_allowed), .o_tb_tick(o_tb_tick),
        .o_tb_idle(o_tb_idle), .o_output_pin_enable(o_output_pin_enable), .o_pwm_pin(o_pwm_pin));

    // A unit-two copy on the same bus, whose outputs C to F must be missing.
    smpu_cfg #(.UNIT_NUM(2)) uut2 (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata_u2), .i_pll_clk_tick(i_pll_clk_tick),
        .i_external_clock_pin(i_external_clock_pin), .i_period_evt(i_period_evt), .i_phase_evt(i_phase_evt),
        .i_sync_out_units(i_sync_out_units), .i_async_period_evt(i_async_period_evt),
        .i_async_duty_evt(i_async_duty_evt), .i_external_event_input(i_external_event_input),
        .i_rise_blank_active(i_rise_blank_active), .i_fall_blank_active(i_fall_blank_active),
        .i_pwm_raw(i_pwm_raw), .o_sync_out(), .o_sync_in(), .o_latch_set(), .o_period_evt(), .o_duty_evt(),
        .o_ext_evt(), .o_rise_evt_allowed(), .o_fall_evt_allowed(), .o_tb_tick(), .o_tb_idle(),
        .o_output_pin_enable(), .o_pwm_pin());

    smpu_power_stage stage (.i_pwm_pin(o_pwm_pin), .i_output_pin_enable(o_output_pin_enable),
        .i_port_level(6'h2D), .o_gate(gate));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, and source ticks: the PLL tick every second cycle, a pin edge every fourth, so each source differs.
    always #50 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 2'h1;
        i_pll_clk_tick <= cyc[0];
        i_external_clock_pin <= cyc[1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparison, bus cycles and verdict.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t ns: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_rd   <= 1'b0;
        @(negedge i_sys_clk);
        chk(o_rdata, exp, what);
    endtask
    task automatic summarize();
        if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Reset values, writable bits, unmapped offsets, then a reset in mid-run. No reserved sync or blank code is written.
    task automatic t_regs();
        logic [7:0] wv [6] = '{8'hFC, 8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'hDD};
        logic [7:0] mk [6] = '{8'hE7, 8'hE7, 8'h33, 8'h3F, 8'h7F, 8'h33};
        logic [7:0] m2 [6] = '{8'hE7, 8'hE7, 8'h33, 8'h03, 8'h43, 8'h33};
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], 8'h00, "reset value");
            wr(a[3:0], (a < 6) ? wv[a] : 8'hFF);
            rd(a[3:0], (a < 6) ? (wv[a] & mk[a]) : 8'h00, "readback");
            chk(rdata_u2, (a < 6) ? (wv[a] & m2[a]) : 8'h00, "unit two readback");
        end
        @(posedge i_sys_clk);
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        chk({2'b0, o_output_pin_enable}, 8'h00, "enable after reset");
        for (int a = 0; a < 6; a++) rd(a[3:0], 8'h00, "second reset");
    endtask

    // Sync routing over both phase offset settings and every legal sync code.
    task automatic t_sync();
        logic [3:0] u;
        logic       si;
        for (int po = 0; po < 2; po++)
            for (int c = 0; c < 5; c++) begin // codes above 100 are never written
                wr(`SMPU_OFS_SYNC_U3, {po[0], po[0], ~po[0], 2'b00, c[2:0]});
                for (int p = 0; p < 2; p++) begin
                    u = p[0] ? 4'hA : 4'h5;
                    si = (c == 0) ? p[0] : u[c-1];
                    @(posedge i_sys_clk);
                    i_sync_out_units <= u;
                    i_period_evt <= p[0];
                    i_phase_evt <= ~p[0];
                    i_async_period_evt <= p[0];
                    i_async_duty_evt <= ~p[0];
                    @(posedge i_sys_clk);
                    @(negedge i_sys_clk);
                    chk({3'b0, o_sync_out, o_sync_in, o_latch_set, o_period_evt, o_duty_evt},
                        {3'b0, p[0] ^ po[0], si, po[0] ? si : ~p[0], p[0] ^ po[0], p[0] ^ po[0]},
                        "sync routing");
                end
            end
    endtask

    // Tick count over 64 cycles for every source and prescale code.
    task automatic t_clk();
        logic [7:0] n;
        for (int s = 0; s < 4; s++)
            for (int pre = 0; pre < 4; pre++) begin
                wr(`SMPU_OFS_CLK_SEL, {2'b00, pre[1:0], 2'b00, s[1:0]});
                repeat (40) @(posedge i_sys_clk); // the old prescale count must drain first
                n = 8'h00;
                repeat (64) begin
                    @(negedge i_sys_clk);
                    n = n + o_tb_tick;
                end
                chk(n, (s == 3) ? 8'h00 : (8'h40 >> (pre + s)), "tick count");
                chk({7'b0, o_tb_idle}, {7'b0, s == 3}, "idle flag");
            end
    endtask

    // Pin enables and polarities, the event input polarity, and the pin level at the stage.
    task automatic t_pins();
        logic [23:0] v [4] = '{24'h3F_00_2A, 24'h3F_7F_2A, 24'h15_4A_33, 24'h00_3F_3F};
        logic [5:0]  p;
        for (int k = 0; k < 4; k++) begin
            wr(`SMPU_OFS_OUT_EN, {2'b00, v[k][21:16]});
            wr(`SMPU_OFS_OUT_POL, {1'b0, v[k][14:8]});
            p = (v[k][5:0] ^ v[k][13:8]) & v[k][21:16];
            @(posedge i_sys_clk);
            i_pwm_raw <= v[k][5:0];
            i_external_event_input <= k[0];
            @(posedge i_sys_clk);
            @(negedge i_sys_clk);
            chk({2'b0, o_output_pin_enable}, {2'b0, v[k][21:16]}, "enable copy");
            chk({2'b0, o_pwm_pin}, {2'b0, p}, "pwm pins");
            chk({2'b0, gate}, {2'b0, p | (6'h2D & ~v[k][21:16])}, "stage gate");
            chk({7'b0, o_ext_evt}, {7'b0, k[0] ^ v[k][14]}, "event input");
        end
    endtask

    // Blanking modes none and immediate against every open window.
    task automatic t_blank();
        for (int m = 0; m < 4; m++) begin
            wr(`SMPU_OFS_BLANK_MODE, {3'b000, m[1], 3'b000, m[0]});
            for (int act = 0; act < 4; act++) begin
                @(posedge i_sys_clk);
                i_rise_blank_active <= act[0];
                i_fall_blank_active <= act[1];
                @(posedge i_sys_clk);
                @(negedge i_sys_clk);
                chk({6'b0, o_rise_evt_allowed, o_fall_evt_allowed},
                    {6'b0, ~(m[0] & act[0]), ~(m[1] & act[1])}, "blanking");
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (8) @(posedge i_sys_clk);
        chk({6'b0, o_rise_evt_allowed, o_fall_evt_allowed}, 8'h03, "allowed in reset");
        i_arst_n <= 1'b1;
        t_regs();
        t_sync();
        t_clk();
        t_pins();
        t_blank();
        summarize();
    end

    // Watchdog: the whole sequence needs about 1900 cycles.
    initial begin
        repeat (6000) @(posedge i_sys_clk);
        miscompares++;
        summarize();
    end
endmodule
